/* File: logic/relay_sel_cfg.svh */
// Constants for the relay status output selector.
// Assumes inclusion by the design module and the testbench only.
`ifndef RELAY_SEL_CFG_SVH
`define RELAY_SEL_CFG_SVH
`define ADDR_FUNC_SEL   8'h00
`define ADDR_UPPER_TH   8'h04
`define ADDR_LOWER_TH   8'h08
`define ADDR_AIN2_LIM   8'h0c
`define ADDR_STATUS     8'h10
`define ADDR_INT_STAT   8'h14
`define ADDR_INT_CLR    8'h18
`define ADDR_INT_EN     8'h1c
`define SEL_RUN         4'h0
`define SEL_HEALTHY     4'h1
`define SEL_AT_SPEED    4'h2
`define SEL_FREQ_NZ     4'h3
`define SEL_SPEED_LIM   4'h4
`define SEL_CURR_LIM    4'h5
`define SEL_TORQ_LIM    4'h6
`define SEL_AIN2_LIM    4'h7
`define SEL_PUMP        4'h8
`define SEL_FIRE        4'h9
`define SEL_MAINT       4'ha
`define SEL_AUTO_RDY    4'hb
`define SEL_TRIP        4'hc
`define SEL_INHIBIT     4'hd
`define SEL_PID_ERR     4'he
`define SEL_LOAD        4'hf
`define FUNC_SEL_RST    4'h1
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

/* File: logic/relay_sel_pkg.sv */
// Types shared by the relay selector.
// Assumes the cfg header for numeric constants.
package relay_sel_pkg;
    typedef struct packed {
        logic        run;
        logic        healthy;
        logic        at_speed;
        logic        freq_nz;
        logic        pump;
        logic        fire;
        logic        maint;
        logic        auto_mode;
        logic        tripped;
        logic        safety_ok;
        logic        inhibit_a;
        logic        inhibit_b;
        logic        can_run;
        logic        load_alarm;
    } drive_flags_s;

    typedef struct packed {
        logic [15:0] speed;
        logic [15:0] current;
        logic [15:0] torque;
        logic [15:0] ain2;
        logic [15:0] pid_err;
    } drive_meas_s;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WR   = 3'b010,
        BUS_RD   = 3'b100
    } bus_state_e;
endpackage : relay_sel_pkg

/* File: logic/relay_sel.sv */
// Relay output function selector with hysteresis and AXI4-Lite registers.
// Assumes status flags are synchronous to sys_clk; measurements are unsigned.
// Operation
// - Function select register chooses which status condition drives the relay.
// - Limit selections switch relay on when quantity exceeds upper threshold.
// - Limit selections switch relay off only below lower threshold.
// - Selection 0: relay on while motor enabled and running.
// - Selection 1: relay on while powered with no fault.
// - Selection 2: relay on while output frequency matches setpoint.
// - Selection 3: relay on while output frequency above zero.
// - Selection 4: relay on when speed exceeds limit, with hysteresis.
// - Selection 5: relay on when current exceeds limit, with hysteresis.
// - Selection 6: relay on when torque exceeds limit, with hysteresis.
// - Selection 9: relay on while emergency override mode active.
// - Selection 10: relay on when maintenance is due.
// - Auto-ready: relay on in auto mode, no trips, safety enabled.
// - Selection 12: relay on while tripped showing fault code.
// - Selection 13: relay on when both inhibit inputs present and drive can run.
// - Selection 14: relay on when PID error reaches programmed limit.
// - Selection 15: relay on when load monitor detects abnormal load.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`include "relay_sel_cfg.svh"
module relay_sel
    import relay_sel_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire drive_flags_s flags,
    input  wire drive_meas_s  meas,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output logic              relay2_out,
    output logic              irq
);

    typedef struct packed {
        logic [3:0]   func_sel;
        logic [W-1:0] upper_th;
        logic [W-1:0] lower_th;
        logic [W-1:0] ain2_lim;
        logic [4:0]   hyst;
        logic         relay;
        logic         relay_prev;
        logic [1:0]   int_stat;
        logic [1:0]   int_en;
        logic         irq;
        logic         aw_got;
        logic         w_got;
        logic [7:0]   awaddr;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic         awready;
        logic         wready;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arready;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    logic [W-1:0] q [5];
    logic         cond;
    logic         is_lim;
    logic [2:0]   lim_idx;

    assign q[0] = meas.speed[W-1:0];
    assign q[1] = meas.current[W-1:0];
    assign q[2] = meas.torque[W-1:0];
    assign q[3] = meas.ain2[W-1:0];
    assign q[4] = meas.pid_err[W-1:0];

    // Per-quantity hysteresis comparators
    logic [4:0] hyst_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_hyst
            // PID error sets at equality as well
            always_comb begin
                if (q[gi] > st_ff.upper_th || (gi == 4 && q[gi] == st_ff.upper_th)) begin
                    hyst_nxt[gi] = 1'b1;
                end else if (q[gi] < st_ff.lower_th) begin
                    hyst_nxt[gi] = 1'b0;
                end else begin
                    hyst_nxt[gi] = st_ff.hyst[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        is_lim  = 1'b0;
        lim_idx = 3'd0;
        cond    = 1'b0;
        case (st_ff.func_sel)
            `SEL_RUN:      cond = flags.run;
            `SEL_HEALTHY:  cond = flags.healthy;
            `SEL_AT_SPEED: cond = flags.at_speed;
            `SEL_FREQ_NZ:  cond = flags.freq_nz;
            `SEL_SPEED_LIM: begin
                is_lim  = 1'b1;
                lim_idx = 3'd0;
            end
            `SEL_CURR_LIM: begin
                is_lim  = 1'b1;
                lim_idx = 3'd1;
            end
            `SEL_TORQ_LIM: begin
                is_lim  = 1'b1;
                lim_idx = 3'd2;
            end
            `SEL_AIN2_LIM: begin
                is_lim  = 1'b1;
                lim_idx = 3'd3;
            end
            `SEL_PUMP:     cond = flags.pump;
            `SEL_FIRE:     cond = flags.fire;
            `SEL_MAINT:    cond = flags.maint;
            `SEL_AUTO_RDY: cond = flags.auto_mode & ~flags.tripped & flags.safety_ok;
            `SEL_TRIP:     cond = flags.tripped;
            `SEL_INHIBIT:  cond = flags.inhibit_a & flags.inhibit_b & flags.can_run;
            `SEL_PID_ERR: begin
                is_lim  = 1'b1;
                lim_idx = 3'd4;
            end
            `SEL_LOAD:     cond = flags.load_alarm;
            default:       cond = 1'b0;
        endcase
        if (is_lim) begin
            cond = hyst_nxt[lim_idx];
        end
    end

    logic        wr_fire;
    logic        rd_fire;
    logic [31:0] rd_val;
    logic        rd_ok;
    logic        wr_ok;
    logic        rise;
    logic        fall;

    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            `ADDR_FUNC_SEL: rd_val = {28'h0, st_ff.func_sel};
            `ADDR_UPPER_TH: rd_val = 32'(st_ff.upper_th);
            `ADDR_LOWER_TH: rd_val = 32'(st_ff.lower_th);
            `ADDR_AIN2_LIM: rd_val = 32'(st_ff.ain2_lim);
            `ADDR_STATUS:   rd_val = {26'h0, st_ff.hyst, st_ff.relay};
            `ADDR_INT_STAT: rd_val = {30'h0, st_ff.int_stat};
            `ADDR_INT_CLR:  rd_val = 32'h0000_0000;
            `ADDR_INT_EN:   rd_val = {30'h0, st_ff.int_en};
            default:        rd_ok  = 1'b0;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        // Relay follows condition every cycle
        nxt_st.hyst       = hyst_nxt;
        nxt_st.relay      = cond;
        nxt_st.relay_prev = st_ff.relay;
        rise = st_ff.relay & ~st_ff.relay_prev;
        fall = ~st_ff.relay & st_ff.relay_prev;

        // Write channel: address and data in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.awaddr  = s_axi_awaddr;
            nxt_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got  = 1'b1;
            nxt_st.wdata  = s_axi_wdata;
            nxt_st.wstrb  = s_axi_wstrb;
            nxt_st.wready = 1'b0;
        end
        wr_fire = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
        wr_ok   = 1'b1;
        if (wr_fire) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            case (st_ff.awaddr)
                `ADDR_FUNC_SEL: begin
                    if (st_ff.wstrb[0]) nxt_st.func_sel = st_ff.wdata[3:0];
                end
                `ADDR_UPPER_TH: begin
                    if (st_ff.wstrb[0]) nxt_st.upper_th[7:0] = st_ff.wdata[7:0];
                    if (st_ff.wstrb[1]) nxt_st.upper_th[W-1:8] = st_ff.wdata[W-1:8];
                end
                `ADDR_LOWER_TH: begin
                    if (st_ff.wstrb[0]) nxt_st.lower_th[7:0] = st_ff.wdata[7:0];
                    if (st_ff.wstrb[1]) nxt_st.lower_th[W-1:8] = st_ff.wdata[W-1:8];
                end
                `ADDR_AIN2_LIM: begin
                    if (st_ff.wstrb[0]) nxt_st.ain2_lim[7:0] = st_ff.wdata[7:0];
                    if (st_ff.wstrb[1]) nxt_st.ain2_lim[W-1:8] = st_ff.wdata[W-1:8];
                end
                `ADDR_INT_CLR: begin
                    if (st_ff.wstrb[0]) nxt_st.int_stat = st_ff.int_stat & ~st_ff.wdata[1:0];
                end
                `ADDR_INT_EN: begin
                    if (st_ff.wstrb[0]) nxt_st.int_en = st_ff.wdata[1:0];
                end
                `ADDR_STATUS, `ADDR_INT_STAT: ;
                default: wr_ok = 1'b0;
            endcase
            nxt_st.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        // Set wins over clear
        if (rise) nxt_st.int_stat[0] = 1'b1;
        if (fall) nxt_st.int_stat[1] = 1'b1;
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid  = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready  = 1'b1;
        end

        // Read channel
        rd_fire = s_axi_arvalid & st_ff.arready;
        if (rd_fire) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid  = 1'b1;
            nxt_st.rdata   = rd_val;
            nxt_st.rresp   = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid  = 1'b0;
            nxt_st.arready = 1'b1;
        end
        nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_en);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_ff          <= '0;
            st_ff.func_sel <= `FUNC_SEL_RST;
            st_ff.awready  <= 1'b1;
            st_ff.wready   <= 1'b1;
            st_ff.arready  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready  = st_ff.wready;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    assign relay2_out    = st_ff.relay;
    assign irq           = st_ff.irq;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_run_follow: assert property (
        (st_ff.func_sel == `SEL_RUN) && $stable(st_ff.func_sel) |=> relay2_out == $past(flags.run))
        else $error("relay not following run flag");
    chk_healthy_follow: assert property (
        (st_ff.func_sel == `SEL_HEALTHY) |=> relay2_out == $past(flags.healthy)
            || $past(st_ff.func_sel) != `SEL_HEALTHY)
        else $error("relay not following healthy flag");
    chk_upper_set: assert property (
        (st_ff.func_sel == `SEL_SPEED_LIM) && (meas.speed > st_ff.upper_th) |=> relay2_out
            || $past(st_ff.func_sel) != `SEL_SPEED_LIM)
        else $error("relay not set above upper threshold");
    chk_lower_clear: assert property (
        (st_ff.func_sel == `SEL_CURR_LIM) && relay2_out && (meas.current >= st_ff.lower_th)
            && $stable(st_ff.func_sel) |=> relay2_out || $past(st_ff.func_sel) != `SEL_CURR_LIM)
        else $error("relay cleared above lower threshold");
    chk_trip_follow: assert property (
        (st_ff.func_sel == `SEL_TRIP) ##1 (st_ff.func_sel == `SEL_TRIP)
            |-> relay2_out == $past(flags.tripped))
        else $error("relay not following trip");
    chk_auto_ready: assert property (
        (st_ff.func_sel == `SEL_AUTO_RDY) && flags.tripped ##1 (st_ff.func_sel == `SEL_AUTO_RDY)
            |-> !relay2_out)
        else $error("auto ready asserted while tripped");
    chk_inhibit_both: assert property (
        (st_ff.func_sel == `SEL_INHIBIT) && !flags.inhibit_a ##1 (st_ff.func_sel == `SEL_INHIBIT)
            |-> !relay2_out)
        else $error("inhibit status with missing input");
    chk_pid_limit: assert property (
        (st_ff.func_sel == `SEL_PID_ERR) && (meas.pid_err == st_ff.upper_th)
            ##1 (st_ff.func_sel == `SEL_PID_ERR) |-> relay2_out)
        else $error("pid error at limit not signalled");
    chk_irq_level: assert property (
        (|(st_ff.int_stat & st_ff.int_en)) && !(st_ff.aw_got && st_ff.w_got) |=> irq)
        else $error("irq low with enabled status");

    // Plain selections: relay shows the flag one edge later
    chk_at_speed_follow: assert property (
        (st_ff.func_sel == `SEL_AT_SPEED) |=> relay2_out == $past(flags.at_speed))
        else $error("relay not following at-speed flag");
    chk_freq_follow: assert property (
        (st_ff.func_sel == `SEL_FREQ_NZ) |=> relay2_out == $past(flags.freq_nz))
        else $error("relay not following frequency flag");
    chk_fire_follow: assert property (
        (st_ff.func_sel == `SEL_FIRE) |=> relay2_out == $past(flags.fire))
        else $error("relay not following override mode");
    chk_maint_follow: assert property (
        (st_ff.func_sel == `SEL_MAINT) |=> relay2_out == $past(flags.maint))
        else $error("relay not following maintenance due");
    chk_load_follow: assert property (
        (st_ff.func_sel == `SEL_LOAD) |=> relay2_out == $past(flags.load_alarm))
        else $error("relay not following load alarm");
    chk_inhibit_all: assert property (
        (st_ff.func_sel == `SEL_INHIBIT) && flags.inhibit_a && flags.inhibit_b
            && flags.can_run |=> relay2_out)
        else $error("inhibit status missing with both inputs");
    chk_auto_ok: assert property (
        (st_ff.func_sel == `SEL_AUTO_RDY) && flags.auto_mode && !flags.tripped
            && flags.safety_ok |=> relay2_out)
        else $error("auto ready missing");

    // Limit selections: hysteresis between the two thresholds
    chk_current_set: assert property (
        (st_ff.func_sel == `SEL_CURR_LIM) && (meas.current > st_ff.upper_th) |=> relay2_out)
        else $error("relay not set above current limit");
    chk_speed_clear: assert property (
        (st_ff.func_sel == `SEL_SPEED_LIM) && (meas.speed < st_ff.lower_th)
            && (meas.speed <= st_ff.upper_th) |=> !relay2_out)
        else $error("relay not cleared below lower threshold");
    chk_torque_hold: assert property (
        (st_ff.func_sel == `SEL_TORQ_LIM) && $stable(st_ff.func_sel) && relay2_out
            && (meas.torque >= st_ff.lower_th) |=> relay2_out)
        else $error("torque relay dropped inside hysteresis band");
    chk_pid_hold: assert property (
        (st_ff.func_sel == `SEL_PID_ERR) && $stable(st_ff.func_sel) && relay2_out
            && (meas.pid_err >= st_ff.lower_th) |=> relay2_out)
        else $error("pid relay dropped inside hysteresis band");

    // Relay edges latch into the sticky status
    chk_rise_status: assert property (
        $rose(relay2_out) |=> st_ff.int_stat[0])
        else $error("relay rise not latched");
    chk_fall_status: assert property (
        $fell(relay2_out) |=> st_ff.int_stat[1])
        else $error("relay fall not latched");

    cov_limit_cycle: cover property (
        (st_ff.func_sel == `SEL_TORQ_LIM) && relay2_out ##[1:50] !relay2_out);
    cov_write_done: cover property (s_axi_bvalid && s_axi_bready);
    cov_read_done: cover property (s_axi_rvalid && s_axi_rready);
    cov_irq: cover property ($rose(irq));
    cov_pid_band: cover property (
        (st_ff.func_sel == `SEL_PID_ERR) && relay2_out && (meas.pid_err < st_ff.upper_th));

endmodule : relay_sel

/* File: sim/relay_contact_model.sv */
// Model of external equipment wired to the relay contacts.
// Assumes relay2_out is a registered level in the sys_clk domain.
module relay_contact_model (
    input  wire logic sys_clk,
    input  wire logic relay2_out,
    output int        closures
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_ff = 1'b0;
    int   cnt_ff  = 0;

    assign closures = cnt_ff;

    // Counts contact closures as seen by the load
    always @(posedge sys_clk) begin
        if (relay2_out && !last_ff) begin
            cnt_ff <= cnt_ff + 1;
        end
        last_ff <= relay2_out;
    end
endmodule : relay_contact_model

/* File: sim/relay_sel_tb_top.sv */
// Self-checking bench for the relay selector with a reference model.
// Assumes the package and the cfg header are on the include path.
`include "relay_sel_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module relay_sel_tb_top
    import relay_sel_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic         sys_clk = 1'b0;
    logic         rst_b   = 1'b0;
    drive_flags_s flags   = '0;
    drive_meas_s  meas    = '0;
    logic [7:0]   awaddr  = 8'h00;
    logic [7:0]   araddr  = 8'h00;
    logic [31:0]  wdata   = 32'h0;
    logic         awvalid = 1'b0;
    logic         wvalid  = 1'b0;
    logic         bready  = 1'b0;
    logic         arvalid = 1'b0;
    logic         rready  = 1'b0;
    logic         awready, wready, bvalid, arready, rvalid, relay2_out, irq;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata;
    int           error_cnt = 0, samples_checked = 0, closures;
    int           sel = 1, up = 0, lo = 0, stat = 0, en = 0, rises = 0;
    int           hy[5] = '{default: 0};
    logic         exp_rly = 1'b0;
    logic [15:0]  bnd[5] = '{16'h03e8, 16'h03e9, 16'h03e8, 16'h01f4, 16'h01f3};

    always #12.5 sys_clk = ~sys_clk;

    relay_sel dut (.sys_clk(sys_clk), .rst_b(rst_b), .flags(flags), .meas(meas),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .relay2_out(relay2_out),
        .irq(irq));

    relay_contact_model contact (.sys_clk(sys_clk), .relay2_out(relay2_out),
        .closures(closures));

    function automatic int qv(int i);
        case (i)
            0: return meas.speed;
            1: return meas.current;
            2: return meas.torque;
            3: return meas.ain2;
            default: return meas.pid_err;
        endcase
    endfunction : qv

    function automatic logic mdl();
        case (sel)
            0: return flags.run;
            1: return flags.healthy;
            2: return flags.at_speed;
            3: return flags.freq_nz;
            4, 5, 6, 7: return hy[sel - 4] != 0;
            8: return flags.pump;
            9: return flags.fire;
            10: return flags.maint;
            11: return flags.auto_mode && !flags.tripped && flags.safety_ok;
            12: return flags.tripped;
            13: return flags.inhibit_a && flags.inhibit_b && flags.can_run;
            14: return hy[4] != 0;
            default: return flags.load_alarm;
        endcase
    endfunction : mdl

    function automatic logic [15:0] rq();
        return 16'($urandom_range(1200, 300));
    endfunction : rq

    // Lets relay, status and irq land, then compares with the model
    task automatic settle();
        logic r;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            if (qv(i) > up || (i == 4 && qv(i) == up)) hy[i] = 1;
            else if (qv(i) < lo) hy[i] = 0;
        end
        r = mdl();
        if (r && !exp_rly) begin
            stat |= 1;
            rises++;
        end
        if (!r && exp_rly) stat |= 2;
        exp_rly = r;
        `CHK("relay2_out", exp_rly, relay2_out)
        `CHK("irq", (stat & en) != 0, irq)
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!(bvalid && bready) && n < 40);
        bready <= 1'b0;
        `CHK("bvalid", 1'b1, bvalid)
        `CHK("bresp", er, bresp)
        if (er == `RESP_OKAY) begin
            case (a)
                `ADDR_FUNC_SEL: sel = int'(d[3:0]);
                `ADDR_UPPER_TH: up = int'(d[15:0]);
                `ADDR_LOWER_TH: lo = int'(d[15:0]);
                `ADDR_INT_CLR:  stat &= ~int'(d[1:0]);
                `ADDR_INT_EN:   en = int'(d[1:0]);
                default: ;
            endcase
        end
        settle();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!(rvalid && rready) && n < 40);
        rready <= 1'b0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rresp", er, rresp)
        `CHK("rdata", e, rdata)
        @(posedge sys_clk);
    endtask : rd

    task automatic summarize();
        if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    initial begin
        logic [31:0] rv;
        void'($urandom(32'hf636));
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(`ADDR_FUNC_SEL, 32'h1, `RESP_OKAY);
        rd(`ADDR_UPPER_TH, 32'h0, `RESP_OKAY);
        rd(`ADDR_LOWER_TH, 32'h0, `RESP_OKAY);
        rd(8'h20, 32'h0, `RESP_SLVERR);
        wr(8'h24, 32'h5, `RESP_SLVERR);
        wr(`ADDR_INT_EN, 32'h3, `RESP_OKAY);
        wr(`ADDR_LOWER_TH, 32'd500, `RESP_OKAY);
        wr(`ADDR_UPPER_TH, 32'd1000, `RESP_OKAY);
        rd(`ADDR_UPPER_TH, 32'd1000, `RESP_OKAY);
        // Threshold edges: equal values must not switch speed; PID error also sets at equality
        wr(`ADDR_FUNC_SEL, 32'h4, `RESP_OKAY);
        foreach (bnd[i]) begin
            meas.speed <= bnd[i];
            settle();
        end
        wr(`ADDR_FUNC_SEL, 32'he, `RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            meas.pid_err <= 16'(1001 - i);
            settle();
        end
        for (int s = 0; s < 16; s++) begin
            wr(`ADDR_FUNC_SEL, 32'(s), `RESP_OKAY);
            rd(`ADDR_FUNC_SEL, 32'(s), `RESP_OKAY);
            repeat (12) begin
                rv = $urandom;
                flags <= rv[13:0];
                meas <= {rq(), rq(), rq(), rq(), rq()};
                settle();
            end
        end
        rv = {26'h0, hy[4][0], hy[3][0], hy[2][0], hy[1][0], hy[0][0], exp_rly};
        rd(`ADDR_STATUS, rv, `RESP_OKAY);
        wr(`ADDR_AIN2_LIM, 32'h0000_0abc, `RESP_OKAY);
        rd(`ADDR_AIN2_LIM, 32'h0000_0abc, `RESP_OKAY);
        rd(`ADDR_INT_STAT, 32'(stat), `RESP_OKAY);
        wr(`ADDR_INT_CLR, 32'h3, `RESP_OKAY);
        rd(`ADDR_INT_STAT, 32'h0, `RESP_OKAY);
        wr(`ADDR_INT_EN, 32'h0, `RESP_OKAY);
        wr(`ADDR_FUNC_SEL, 32'h0, `RESP_OKAY);
        flags.run <= ~flags.run;
        settle();
        flags.run <= ~flags.run;
        settle();
        wr(`ADDR_INT_EN, 32'h3, `RESP_OKAY);
        `CHK("closures", rises, closures)
        summarize();
    end

    initial begin
        #(25ns * 40000);
        `CHK("watchdog", 1'b0, 1'b1)
        summarize();
    end
endmodule : relay_sel_tb_top
